/* File: design/tpcs_timer_clock.sv */
`timescale 1ns/1ps
`include "tpcs_params.svh"
// ************************************************************
// ************************************************************
module tpcs_timer_clock
#(
    parameter int PRE_W = `TPCS_PRE_BITS
)
(
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // Wishbone slave
    input wire tpcs_pkg::tpcs_wb_req_s WB_REQ,
    output tpcs_pkg::tpcs_wb_rsp_s WB_RSP,
    // Pins
    input wire logic EXT_COUNT_IN,
    input wire logic CAPTURE_IN,
    // Timer status
    output logic TIMER_TICK,
    output logic TIMER_REQ,
    output logic [15:0] COUNT_VALUE
);
    import tpcs_pkg::*;

    // ********************************************************
    // Bus decode
    // ********************************************************
    tpcs_wb_rsp_s rsp_reg;
    logic sync_hold_mode_reg;
    logic prescaler_reset_bit_reg;
    tpcs_clk_sel_e clock_select_field_reg;
    logic [15:0] cnt_reg;
    logic [7:0] compare_a_value_reg;
    logic [7:0] compare_b_value_reg;
    logic [3:0] timer_flag_register_reg;
    logic [3:0] timer_mask_register_reg;
    logic [1:0] mode_reg;
    logic tick_reg;
    logic req_reg;

    wire bus_req = WB_REQ.cyc & WB_REQ.stb & ~rsp_reg.ack;
    wire bus_wr = bus_req & WB_REQ.we & WB_REQ.sel[0];
    wire [7:0] idx = WB_REQ.adr[9:2];
    wire [7:0] wdat = WB_REQ.dat[7:0];
    wire hit_ctrl = idx == `TPCS_IDX_CTRL;
    wire hit_cntl = idx == `TPCS_IDX_CNTL;
    wire hit_cnth = idx == `TPCS_IDX_CNTH;
    wire hit_cmpa = idx == `TPCS_IDX_CMPA;
    wire hit_cmpb = idx == `TPCS_IDX_CMPB;
    wire hit_flag = idx == `TPCS_IDX_FLAG;
    wire hit_mask = idx == `TPCS_IDX_MASK;
    wire hit_mode = idx == `TPCS_IDX_MODE;
    wire wr_ctrl = bus_wr & hit_ctrl;
    wire wr_cntl = bus_wr & hit_cntl;
    wire wr_cnth = bus_wr & hit_cnth;
    wire cnt_wr = wr_cntl | wr_cnth;

    // Upper control bits read as zero
    wire [7:0] ctrl_rd = {3'b000, sync_hold_mode_reg,
        prescaler_reset_bit_reg, clock_select_field_reg};
    // Unmapped addresses answer with zero data
    wire [7:0] rd_data =
        hit_ctrl ? ctrl_rd :
        hit_cntl ? cnt_reg[7:0] :
        hit_cnth ? cnt_reg[15:8] :
        hit_cmpa ? compare_a_value_reg :
        hit_cmpb ? compare_b_value_reg :
        hit_flag ? {4'h0, timer_flag_register_reg} :
        hit_mask ? {4'h0, timer_mask_register_reg} :
        hit_mode ? {6'h00, mode_reg} : 8'h00;

    // ********************************************************
    // Control register and prescaler
    // ********************************************************
    logic [PRE_W-1:0] pre_reg;
    logic [3:0] tap;

    // Hold mode keeps whatever was written
    // Otherwise the bit lives for one cycle only
    wire psr_next = wr_ctrl ? wdat[`TPCS_PSR_BIT] :
        (sync_hold_mode_reg & prescaler_reset_bit_reg);
    wire tsm_next = wr_ctrl ? wdat[`TPCS_TSM_BIT] : sync_hold_mode_reg;
    wire [2:0] cs_next = wr_ctrl ? wdat[`TPCS_CS_MSB:`TPCS_CS_LSB] :
        clock_select_field_reg;

    // Taps fire when the low bits of the count are all ones
    localparam int TAP_BITS [4] = '{`TPCS_TAP8_BITS, `TPCS_TAP64_BITS,
        `TPCS_TAP256_BITS, `TPCS_TAP1024_BITS};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_tap
            assign tap[gi] = &pre_reg[TAP_BITS[gi]-1:0];
        end
    endgenerate

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sync_hold_mode_reg <= 1'b0;
            prescaler_reset_bit_reg <= 1'b0;
            clock_select_field_reg <= CS_STOP;
        end
        else if (CE)
        begin
            sync_hold_mode_reg <= tsm_next;
            prescaler_reset_bit_reg <= psr_next;
            clock_select_field_reg <= tpcs_clk_sel_e'(cs_next);
        end
    end

    // Free running, select never touches it
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            pre_reg <= '0;
        else if (CE)
            pre_reg <= prescaler_reset_bit_reg ? '0 : pre_reg + 1'b1;
    end

    // ********************************************************
    // External pin sampling
    // ********************************************************
    // The latch makes the sample half a cycle early
    logic ext_latch;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic cap_s1_reg;
    logic cap_s2_reg;
    logic cap_s3_reg;

    always_latch
    begin
        if (MCLK)
            ext_latch <= EXT_COUNT_IN;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            {ext_s1_reg, ext_s2_reg, ext_s3_reg} <= 3'b000;
            {cap_s1_reg, cap_s2_reg, cap_s3_reg} <= 3'b000;
        end
        else if (CE)
        begin
            {ext_s1_reg, ext_s2_reg, ext_s3_reg} <=
                {ext_latch, ext_s1_reg, ext_s2_reg};
            {cap_s1_reg, cap_s2_reg, cap_s3_reg} <=
                {CAPTURE_IN, cap_s1_reg, cap_s2_reg};
        end
    end

    wire ext_rise = ext_s2_reg & ~ext_s3_reg;
    wire ext_fall = ~ext_s2_reg & ext_s3_reg;

    // ********************************************************
    // Tick selection
    // ********************************************************
    // Edges go straight to the tick, never via taps
    wire tick_src =
        (clock_select_field_reg == CS_DIRECT) ? 1'b1 :
        (clock_select_field_reg == CS_DIV8) ? tap[0] :
        (clock_select_field_reg == CS_DIV64) ? tap[1] :
        (clock_select_field_reg == CS_DIV256) ? tap[2] :
        (clock_select_field_reg == CS_DIV1024) ? tap[3] :
        (clock_select_field_reg == CS_EXT_FALL) ? ext_fall :
        (clock_select_field_reg == CS_EXT_RISE) ? ext_rise :
        1'b0;
    // Held prescaler reset keeps prescaler and counter halted
    wire tick_next = tick_src & ~prescaler_reset_bit_reg;

    // ********************************************************
    // Counter, compare and flags
    // ********************************************************
    wire wide = mode_reg[`TPCS_MODE_W16];
    wire ctc = mode_reg[`TPCS_MODE_CTC] & ~wide;
    wire [15:0] cnt_eff = wide ? cnt_reg : {8'h00, cnt_reg[7:0]};
    wire [15:0] max_val = wide ? `TPCS_MAX16 : `TPCS_MAX8;
    wire [15:0] top_val = ctc ? {8'h00, compare_a_value_reg} :
        max_val;
    wire [15:0] cmp_val = wide ?
        {compare_b_value_reg, compare_a_value_reg} :
        {8'h00, compare_a_value_reg};
    wire at_max = cnt_eff == max_val;
    // Count beyond top lets it run on to MAX and wrap
    wire at_top = (cnt_eff == top_val) | at_max;
    wire [15:0] cnt_inc = at_top ? 16'h0000 : 16'(cnt_eff + 16'h0001);
    wire count_en = tick_reg & ~cnt_wr;
    wire [15:0] cnt_next =
        wr_cntl ? {cnt_reg[15:8], wdat} :
        wr_cnth ? {wdat, cnt_reg[7:0]} :
        count_en ? cnt_inc : cnt_reg;

    wire [3:0] flag_set;
    assign flag_set[`TPCS_FLG_OVF] = count_en & at_max;
    assign flag_set[`TPCS_FLG_CMPA] = count_en & (cnt_eff == cmp_val);
    assign flag_set[`TPCS_FLG_CMPB] = count_en & ~wide &
        (cnt_reg[7:0] == compare_b_value_reg);
    assign flag_set[`TPCS_FLG_CAPT] = cap_s2_reg & ~cap_s3_reg;
    // Write one clears; a set in the same cycle wins
    wire [3:0] flag_clr = (bus_wr & hit_flag) ? wdat[3:0] : 4'h0;
    wire [3:0] flag_next =
        (timer_flag_register_reg & ~flag_clr) | flag_set;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cnt_reg <= `TPCS_CNT_RST;
            compare_a_value_reg <= `TPCS_BYTE_RST;
            compare_b_value_reg <= `TPCS_BYTE_RST;
            timer_flag_register_reg <= `TPCS_FLAG_RST;
            timer_mask_register_reg <= `TPCS_FLAG_RST;
            mode_reg <= 2'b00;
            tick_reg <= 1'b0;
            req_reg <= 1'b0;
        end
        else if (CE)
        begin
            cnt_reg <= cnt_next;
            if (bus_wr & hit_cmpa)
                compare_a_value_reg <= wdat;
            if (bus_wr & hit_cmpb)
                compare_b_value_reg <= wdat;
            if (bus_wr & hit_mask)
                timer_mask_register_reg <= wdat[3:0];
            if (bus_wr & hit_mode)
                mode_reg <= wdat[1:0];
            timer_flag_register_reg <= flag_next;
            tick_reg <= tick_next;
            req_reg <= |(timer_flag_register_reg &
                timer_mask_register_reg);
        end
    end

    // ********************************************************
    // Bus answer, one cycle after the request
    // ********************************************************
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            rsp_reg <= '0;
        else if (CE)
        begin
            rsp_reg.ack <= bus_req;
            rsp_reg.dat <= {24'h000000, rd_data};
        end
    end

    assign WB_RSP = rsp_reg;
    assign TIMER_TICK = tick_reg;
    assign TIMER_REQ = req_reg;
    assign COUNT_VALUE = cnt_reg;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_stop_no_tick: assert property (
        CE && clock_select_field_reg == CS_STOP |=> !tick_reg)
        else $error("tick while stopped");
    a_direct_every_cycle: assert property (
        CE && clock_select_field_reg == CS_DIRECT &&
        !prescaler_reset_bit_reg |=> tick_reg)
        else $error("direct select missed a tick");
    a_div8_tap_only: assert property (
        CE && clock_select_field_reg == CS_DIV8 |=>
        tick_reg == ($past(pre_reg[2:0]) == 3'h7 &&
        !$past(prescaler_reset_bit_reg)))
        else $error("divide by 8 tick misplaced");
    a_psr_self_clear: assert property (
        CE && prescaler_reset_bit_reg && !sync_hold_mode_reg &&
        !wr_ctrl |=> !prescaler_reset_bit_reg)
        else $error("prescaler reset bit not cleared");
    a_hold_keeps_psr: assert property (
        CE && prescaler_reset_bit_reg && sync_hold_mode_reg &&
        !wr_ctrl |=> prescaler_reset_bit_reg && !tick_reg)
        else $error("hold mode lost prescaler reset");
    a_prescaler_runs: assert property (
        !RST && CE && !prescaler_reset_bit_reg |=>
        pre_reg == PRE_W'($past(pre_reg) + 1'b1))
        else $error("prescaler did not advance");
    a_rise_one_tick: assert property (
        CE && clock_select_field_reg == CS_EXT_RISE &&
        !prescaler_reset_bit_reg |=> tick_reg == $past(ext_rise))
        else $error("rising edge tick mismatch");
    a_ovf_at_max: assert property (
        CE && count_en && at_max |=>
        timer_flag_register_reg[`TPCS_FLG_OVF] && cnt_reg == 16'h0000)
        else $error("overflow not flagged at MAX");
    a_cpu_write_wins: assert property (
        CE && wr_cntl |=> cnt_reg[7:0] == $past(wdat))
        else $error("counter write lost");
    a_ack_one_cycle: assert property (
        rsp_reg.ack && CE |=> !rsp_reg.ack)
        else $error("ack held too long");

    c_ext_rise_tick: cover property (
        clock_select_field_reg == CS_EXT_RISE && tick_reg);
    c_div1024_tick: cover property (
        clock_select_field_reg == CS_DIV1024 && tick_reg);
    c_overflow: cover property (flag_set[`TPCS_FLG_OVF]);
    c_hold_release: cover property (
        sync_hold_mode_reg ##1 !sync_hold_mode_reg);

endmodule

/* File: common/tpcs_params.svh */
`ifndef TPCS_PARAMS_SVH
`define TPCS_PARAMS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define TPCS_IDX_CTRL 8'h33
`define TPCS_IDX_CNTL 8'h34
`define TPCS_IDX_CNTH 8'h35
`define TPCS_IDX_CMPA 8'h36
`define TPCS_IDX_CMPB 8'h37
`define TPCS_IDX_FLAG 8'h38
`define TPCS_IDX_MASK 8'h39
`define TPCS_IDX_MODE 8'h3a

// ************************************************************
// Field positions
// ************************************************************
`define TPCS_CS_MSB 2
`define TPCS_CS_LSB 0
`define TPCS_PSR_BIT 3
`define TPCS_TSM_BIT 4
`define TPCS_FLG_OVF 0
`define TPCS_FLG_CMPA 1
`define TPCS_FLG_CMPB 2
`define TPCS_FLG_CAPT 3
`define TPCS_MODE_W16 0
`define TPCS_MODE_CTC 1

// ************************************************************
// Reset values and limits
// ************************************************************
`define TPCS_CTRL_RST 8'h00
`define TPCS_BYTE_RST 8'h00
`define TPCS_CNT_RST 16'h0000
`define TPCS_FLAG_RST 4'h0
`define TPCS_MAX8 16'h00ff
`define TPCS_MAX16 16'hffff

// ************************************************************
// Prescaler taps, in low counter bits that must all be one
// ************************************************************
`define TPCS_PRE_BITS 10
`define TPCS_TAP8_BITS 3
`define TPCS_TAP64_BITS 6
`define TPCS_TAP256_BITS 8
`define TPCS_TAP1024_BITS 10

`endif

/* File: common/tpcs_pkg.sv */
package tpcs_pkg;

    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIRECT = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } tpcs_clk_sel_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tpcs_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tpcs_wb_rsp_s;

endpackage

/* File: sim/tpcs_ext_src.sv */
`timescale 1ns/1ps
// ************************************************************
// External count source
// ************************************************************
module tpcs_ext_src
(
    // Clock and control
    input wire logic clk,
    input wire logic run,
    // Pin and edge counts
    output logic pin,
    output int n_rise,
    output int n_fall
);
    // Three cycles a half period, inside the sampling limit
    localparam int HALF = 3;
    int k = 0;
    logic pin_q = 1'b0;
    int rise_q = 0;
    int fall_q = 0;

    assign pin = pin_q;
    assign n_rise = rise_q;
    assign n_fall = fall_q;

    // Stops only once low, so the pin is stable around select changes
    always @(posedge clk)
    begin
        k <= (k == HALF - 1) ? 0 : k + 1;
        if (k == HALF - 1 && (run || pin_q))
        begin
            pin_q <= ~pin_q;
            if (pin_q)
                fall_q <= fall_q + 1;
            else
                rise_q <= rise_q + 1;
        end
    end
endmodule

/* File: sim/tpcs_timer_clock_tb_top.sv */
`timescale 1ns/1ps
`include "tpcs_params.svh"
module tpcs_timer_clock_tb_top;
    import tpcs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cap = 1'b0;
    logic run = 1'b0;
    logic ce = 1'b1;
    tpcs_wb_req_s req = '0;
    tpcs_wb_rsp_s rsp;
    logic pin, tick, irq;
    logic [15:0] cnt;
    logic [7:0] q;
    int n_rise, n_fall;
    int n_fail = 0;
    int checks_done = 0;

    tpcs_timer_clock tpcs_timer_clock_inst (.MCLK(mclk), .RST(rst),
        .CE(ce), .WB_REQ(req), .WB_RSP(rsp), .EXT_COUNT_IN(pin),
        .CAPTURE_IN(cap), .TIMER_TICK(tick), .TIMER_REQ(irq),
        .COUNT_VALUE(cnt));
    tpcs_ext_src tpcs_ext_src_inst (.clk(mclk), .run(run), .pin(pin),
        .n_rise(n_rise), .n_fall(n_fall));

    always #10 mclk = ~mclk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict;
        $display("Checks done %0d, failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chkr(input string nm, input int g, input int lo,
        input int hi);
        checks_done++;
        if (g < lo || g > hi)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask

    // Classic cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'h1, {24'h0, d}};
        // Only the watchdog ends a wait that never sees ack
        do
            @(posedge mclk);
        while (rsp.ack !== 1'b1);
        q = rsp.dat[7:0];
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e,
        input string nm);
        wb(1'b0, i, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask

    task automatic ticks(input int c, output int n);
        n = 0;
        repeat (c)
        begin
            @(posedge mclk);
            if (tick === 1'b1)
                n++;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rd(`TPCS_IDX_CTRL, 8'h00, "ctrl_rst");
        chk("count_rst", 16'h0000, cnt);
        wb(1'b1, `TPCS_IDX_CTRL, 8'he0);
        rd(`TPCS_IDX_CTRL, 8'h00, "ctrl_ro");
        rd(8'h50, 8'h00, "unmapped");
    endtask

    task automatic t_hold;
        int n;
        wb(1'b1, `TPCS_IDX_CTRL, 8'h19);
        rd(`TPCS_IDX_CTRL, 8'h19, "hold_psr");
        ticks(20, n);
        chkr("held", n, 0, 0);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h01);
        rd(`TPCS_IDX_CTRL, 8'h01, "psr_clr");
        ticks(20, n);
        chkr("direct", n, 20, 20);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h0a);
        rd(`TPCS_IDX_CTRL, 8'h02, "psr_self");
    endtask

    task automatic t_taps;
        int dv[4] = '{8, 64, 256, 1024};
        int k, n;
        for (int s = 0; s < 4; s++)
        begin
            wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
            wb(1'b1, `TPCS_IDX_CTRL, 8'(s + 2));
            k = 0;
            do
            begin
                @(posedge mclk);
                k++;
            end
            while (tick !== 1'b1 && k < 2000);
            chkr("first", k, 1, dv[s] + 1);
            ticks(4 * dv[s], n);
            chkr("period", n, 4, 4);
        end
    endtask

    task automatic t_stop;
        int n;
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
        wb(1'b1, `TPCS_IDX_CNTL, 8'h5a);
        ticks(20, n);
        chkr("stopped", n, 0, 0);
        chk("cnt_hold", 16'h005a, cnt);
        rd(`TPCS_IDX_CNTL, 8'h5a, "cnt_rd");
    endtask

    // Enable low must freeze a running direct count
    task automatic t_freeze;
        wb(1'b1, `TPCS_IDX_CNTL, 8'h33);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h01);
        ce <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("frozen", 16'h0033, cnt);
        ce <= 1'b1;
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
    endtask

    // Select 7 counts rises, select 6 counts falls
    task automatic t_ext(input logic [2:0] s);
        int n, e0, tr, tt;
        logic pq;
        wb(1'b1, `TPCS_IDX_CTRL, {5'h00, s});
        e0 = s[0] ? n_rise : n_fall;
        n = 0;
        tr = -1;
        tt = -1;
        pq = pin;
        run <= 1'b1;
        for (int i = 0; i < 80; i++)
        begin
            @(posedge mclk);
            if (i == 60)
                run <= 1'b0;
            if (pin !== pq && pin === s[0] && tr < 0)
                tr = i;
            if (tick === 1'b1 && tt < 0)
                tt = i;
            if (tick === 1'b1)
                n++;
            pq = pin;
        end
        chkr("latency", tt - tr, 3, 4);
        chkr("edges", n, (s[0] ? n_rise : n_fall) - e0,
            (s[0] ? n_rise : n_fall) - e0);
    endtask

    task automatic t_flags;
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
        wb(1'b1, `TPCS_IDX_MODE, 8'h00);
        wb(1'b1, `TPCS_IDX_MASK, 8'h08);
        wb(1'b1, `TPCS_IDX_CNTL, 8'hfe);
        wb(1'b1, `TPCS_IDX_FLAG, 8'h0f);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h01);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
        wb(1'b0, `TPCS_IDX_FLAG, 8'h00);
        chk("ovf_flag", 16'h0001, {15'h0, q[0]});
        chk("masked", 16'h0000, {15'h0, irq});
        cap <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("capt_req", 16'h0001, {15'h0, irq});
        wb(1'b1, `TPCS_IDX_FLAG, 8'h0f);
        cap <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("cleared", 16'h0000, {15'h0, irq});
    endtask

    task automatic t_wide;
        wb(1'b1, `TPCS_IDX_MODE, 8'h01);
        wb(1'b1, `TPCS_IDX_CNTH, 8'h00);
        wb(1'b1, `TPCS_IDX_CNTL, 8'hfe);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h01);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
        chk("carry", 16'h0001, {8'h00, cnt[15:8]});
        rd(`TPCS_IDX_CNTH, 8'h01, "cnth");
    endtask

    // Compare A as TOP in 8-bit clear-on-match mode
    task automatic t_ctc;
        logic [15:0] mx;
        mx = 16'h0000;
        wb(1'b1, `TPCS_IDX_MODE, 8'h02);
        wb(1'b1, `TPCS_IDX_CMPA, 8'h02);
        wb(1'b1, `TPCS_IDX_CNTH, 8'h00);
        wb(1'b1, `TPCS_IDX_CNTL, 8'h00);
        wb(1'b1, `TPCS_IDX_FLAG, 8'h0f);
        wb(1'b1, `TPCS_IDX_CTRL, 8'h01);
        repeat (12)
        begin
            @(posedge mclk);
            if (cnt > mx)
                mx = cnt;
        end
        wb(1'b1, `TPCS_IDX_CTRL, 8'h00);
        chk("ctc_top", 16'h0002, mx);
        rd(`TPCS_IDX_FLAG, 8'h06, "ctc_flags");
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_hold;
        t_taps;
        t_stop;
        t_freeze;
        t_ext(3'd7);
        t_ext(3'd6);
        t_flags;
        t_wide;
        t_ctc;
        print_verdict;
    end

    // Whole run needs well under ten thousand cycles
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        print_verdict;
    end
endmodule
